// ==== sim/mac_fabric_model.sv ====
// fabric side model: receive frame source and transmit collision or completion answers
`timescale 1ns/1ns
module mac_fabric_model
  import host_mac_pkg::*;
(
  input  wire logic    core_clk,
  input  wire logic    reset_n,
  input  wire logic    tx_active,
  output byte_stream_s rx_in,
  output logic         tx_collision,
  output logic         tx_frame_done
);
  int coll_n;   // collisions still to force on coming attempts
  int act_cnt;  // cycles the mac has been sending

  // ****************************************
  // receive frames
  // ****************************************
  initial begin
    rx_in = '0;
    coll_n = 0;
  end

  // byte i of a test frame: big-endian length field in bytes 12 and 13, index elsewhere
  function automatic logic [7:0] fbyte(input int i, input logic [15:0] len);
    return (i == 12) ? len[15:8] : (i == 13) ? len[7:0] : i[7:0];
  endfunction : fbyte

  // one frame back to back, then an idle line that does not repeat the last byte
  task automatic send_frame(input logic [15:0] len, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      rx_in <= '{1'b1, i == n - 1, fbyte(i, len)};
    end
    @(posedge core_clk);
    rx_in <= '{1'b0, 1'b0, ~fbyte(n - 1, len)};
  endtask : send_frame

  // ****************************************
  // transmit answers
  // ****************************************
  // one cycle into a send: collide while collisions remain, else report the frame done
  always @(posedge core_clk) begin
    tx_collision <= 1'b0;
    tx_frame_done <= 1'b0;
    act_cnt <= (tx_active === 1'b1 && reset_n) ? act_cnt + 1 : 0;
    if (tx_active === 1'b1 && act_cnt == 1) begin
      if (coll_n > 0) begin
        tx_collision <= 1'b1;
        coll_n <= coll_n - 1;
      end else begin
        tx_frame_done <= 1'b1;
      end
    end
  end
endmodule : mac_fabric_model

// ==== sim/test_host_mac_tx_rx_control.sv ====
// testbench of the host mac control block: register access, receive stripping, transmit timing
`timescale 1ns/1ns
`include "host_mac_regs.svh"
module test_host_mac_tx_rx_control
  import host_mac_pkg::*;
;
  logic         core_clk;          // 125 MHz clock
  logic         reset_n;           // synchronous reset
  logic [11:0]  paddr;             // apb address
  logic         psel;              // apb select
  logic         penable;           // apb enable
  logic         pwrite;            // apb direction
  logic [31:0]  pwdata;            // apb write data
  logic [3:0]   pstrb;             // apb lanes
  logic [31:0]  prdata;            // apb read data
  logic         pready;            // apb ready
  logic         pslverr;           // apb error
  byte_stream_s rx_in;             // fabric to mac
  byte_stream_s rx_out;            // mac to host
  logic         tx_frame_pending;  // host has a frame
  logic         carrier_sense;     // line busy
  logic         tx_collision;      // collision from fabric
  logic         tx_frame_done;     // frame sent
  logic         tx_active;         // sending
  logic         tx_attempt;        // attempt pulse
  logic         tx_abort_deferral; // deferral abort pulse
  logic         tx_abort_retries;  // retry abort pulse
  logic         tx_complete;       // completion pulse
  int           n_fail;            // mismatches
  int           n_tests;           // comparisons
  int           rx_cnt;            // bytes seen at the host side
  int           rx_last;           // index of the byte flagged last
  int           c;                 // cycles of the last wait
  logic [15:0]  cur_len;           // length field of the frame in flight

  // ****************************************
  // clock, design and fabric
  // ****************************************
  always #4 core_clk = ~core_clk;

  host_mac_tx_rx_control #(.BIT_MHZ(125)) host_mac_tx_rx_control_i (
    .core_clk(core_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_in(rx_in), .rx_out(rx_out), .tx_frame_pending(tx_frame_pending),
    .carrier_sense(carrier_sense), .tx_collision(tx_collision), .tx_frame_done(tx_frame_done),
    .tx_active(tx_active), .tx_attempt(tx_attempt), .tx_abort_deferral(tx_abort_deferral),
    .tx_abort_retries(tx_abort_retries), .tx_complete(tx_complete));

  mac_fabric_model mac_fabric_model_i (
    .core_clk(core_clk), .reset_n(reset_n), .tx_active(tx_active), .rx_in(rx_in),
    .tx_collision(tx_collision), .tx_frame_done(tx_frame_done));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic print_verdict;
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // compare and report one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask : chk

  // one apb transfer: setup, access held until pready, then release
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      $display("Error pready expected 1 seen %b", pready);
      n_fail++;
      print_verdict;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(a, 1'b0, 32'h0, r, e);
    chk("prdata", exp, r);
    chk("pslverr", {31'h0, exp_err}, {31'h0, e});
  endtask : rd

  // wait for a transmit pulse: 0 attempt, 1 deferral abort, 2 complete, 3 retry abort; -1 when none came
  task automatic wait_tx(input int s, input int lim, input bit must, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < lim) begin
      @(posedge core_clk);
      n++;
      hit = (s == 0) ? tx_attempt === 1'b1 : (s == 1) ? tx_abort_deferral === 1'b1 :
            (s == 3) ? tx_abort_retries === 1'b1 : tx_complete === 1'b1;
    end
    if (!hit) n = -1;
    n_tests++;
    if (must && !hit) begin
      $display("Error tx pulse %0d expected within %0d seen none", s, lim);
      n_fail++;
      print_verdict;
    end
  endtask : wait_tx

  // one received frame under a control value, counting what reaches the host
  task automatic rx_case(input logic [31:0] ctrl, input logic [15:0] len, input int n, input int exp);
    wr(`CTRL_ADDR, ctrl);
    rx_cnt = 0;
    rx_last = -1;
    cur_len = len;
    mac_fabric_model_i.send_frame(len, n);
    repeat (3) @(posedge core_clk);
    chk("rx byte count", exp, rx_cnt);
    chk("rx last index", exp - 1, rx_last);
  endtask : rx_case

  // every delivered byte must be the frame byte of the same index
  always @(posedge core_clk) begin
    if (rx_out.valid === 1'b1) begin
      chk("rx byte", {24'h0, mac_fabric_model_i.fbyte(rx_cnt, cur_len)}, {24'h0, rx_out.data});
      if (rx_out.last === 1'b1) rx_last = rx_cnt;
      rx_cnt++;
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    core_clk = 0;
    reset_n = 0;
    paddr = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    pwdata = 0;
    pstrb = 4'hF;
    tx_frame_pending = 0;
    carrier_sense = 0;
    n_fail = 0;
    n_tests = 0;
    rx_cnt = 0;
    rx_last = -1;
    cur_len = 0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    // reset values, unmapped place, writable mask
    rd(`CTRL_ADDR, `CTRL_RESET, 1'b0);
    rd(`STATUS_ADDR, 32'h00000001, 1'b0);
    wr(12'h008, 32'hFFFFFFFF);
    rd(12'h008, 32'h00000000, 1'b1);
    wr(`CTRL_ADDR, 32'hFFFFFFFF);
    rd(`CTRL_ADDR, `CTRL_WMASK, 1'b0);
    // receive: disabled, short, boundary, long, stripping off
    rx_case(32'h000, 16'h0002, 64, 0);
    rx_case(32'h104, 16'h0002, 64, 16);
    rx_case(32'h104, 16'h002D, 64, 59);
    rx_case(32'h104, 16'h002E, 64, 64);
    rx_case(32'h004, 16'h0002, 64, 64);
    // transmit held off while disabled, then one clean frame
    wr(`CTRL_ADDR, 32'h000);
    tx_frame_pending <= 1'b1;
    wait_tx(0, 40, 0, c);
    chk("attempt while disabled", -1, c);
    wr(`CTRL_ADDR, 32'h008);
    wait_tx(0, 20, 1, c);
    tx_frame_pending <= 1'b0;
    wait_tx(2, 20, 1, c);
    // backoff gaps after 1..4 collisions, full range then capped to one bit
    for (int s = 0; s < 2; s++) begin
      wr(`CTRL_ADDR, s ? 32'h0C8 : 32'h008);
      mac_fabric_model_i.coll_n = 4;
      tx_frame_pending <= 1'b1;
      wait_tx(0, 20, 1, c);
      for (int n = 1; n <= 4; n++) begin
        wait_tx(0, s ? 532 : ((1 << n) - 1) * 512 + 20, 1, c);
        if (n == 4) tx_frame_pending <= 1'b0;
      end
      wait_tx(2, 20, 1, c);
    end
    // long deferral, collision, backoff, then deferral counted afresh
    wr(`CTRL_ADDR, 32'h0E8);
    carrier_sense <= 1'b1;
    mac_fabric_model_i.coll_n = 1;
    tx_frame_pending <= 1'b1;
    repeat (15000) @(posedge core_clk);
    carrier_sense <= 1'b0;
    wait_tx(0, 20, 1, c);
    carrier_sense <= 1'b1;
    wait_tx(1, `DEFER_LIMIT_BITS + 1100, 1, c);
    chk("deferral restart", 1, c >= `DEFER_LIMIT_BITS - 8);
    tx_frame_pending <= 1'b0;
    // check off: deferral beyond the limit never aborts
    wr(`CTRL_ADDR, 32'h008);
    tx_frame_pending <= 1'b1;
    wait_tx(1, 24500, 0, c);
    chk("abort with check off", -1, c);
    carrier_sense <= 1'b0;
    wait_tx(0, 20, 1, c);
    tx_frame_pending <= 1'b0;
    wait_tx(2, 20, 1, c);
    // sixteen collisions end the frame with a retry abort, shown in status
    wr(`CTRL_ADDR, 32'h0C8);
    mac_fabric_model_i.coll_n = 16;
    tx_frame_pending <= 1'b1;
    wait_tx(0, 20, 1, c);
    tx_frame_pending <= 1'b0;
    wait_tx(3, 9000, 1, c);
    rd(`STATUS_ADDR, 32'h00001021, 1'b0);
    print_verdict;
  end
endmodule : test_host_mac_tx_rx_control

// ==== src/backoff_lfsr.sv ====
// free running shift register that feeds the random backoff count
`timescale 1ns/1ns
module backoff_lfsr #(
  parameter logic [15:0] SEED = 16'hACE1  // any non-zero start value
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  output logic [15:0]      state_q
);
  // ****************************************
  // galois register, taps 16 14 13 11
  // ****************************************
  wire logic [15:0] shifted = {1'b0, state_q[15:1]};  // plain shift
  wire logic [15:0] state_d = state_q[0] ? (shifted ^ 16'hB400) : shifted;
  // step every cycle so the draw depends on timing
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= SEED;
    end else begin
      state_q <= state_d;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_lfsr_never_zero: assert property (state_q != 16'h0000)
    else $error("backoff shift register stuck at zero");
endmodule : backoff_lfsr

// ==== src/host_mac_pkg.sv ====
// types shared by the host mac control block
package host_mac_pkg;
  // one byte of a frame stream
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } byte_stream_s;
  // transmit sequencing states
  typedef enum logic [3:0] {
    TX_IDLE    = 4'h1,
    TX_DEFER   = 4'h2,
    TX_SEND    = 4'h4,
    TX_BACKOFF = 4'h8
  } tx_state_e;
endpackage : host_mac_pkg

// ==== src/host_mac_regs.svh ====
// register offsets, field positions, reset values and timing counts of the host mac control block
`ifndef HOST_MAC_REGS_SVH
`define HOST_MAC_REGS_SVH
// ****************************************
// register byte addresses
// ****************************************
`define CTRL_ADDR 12'h000
`define STATUS_ADDR 12'h004
// ****************************************
// control fields
// ****************************************
`define PAD_STRIP_BIT 8
`define BACKOFF_SEL_MSB 7
`define BACKOFF_SEL_LSB 6
`define DEFER_CHK_BIT 5
`define TX_EN_BIT 3
`define RX_EN_BIT 2
`define CTRL_WMASK 32'h000001EC
`define CTRL_RESET 32'h00000000
// ****************************************
// timing and frame counts
// ****************************************
`define SLOT_LAST_BIT 9'h1FF
`define DEFER_LIMIT_BITS 16'h5EE0
`define ATTEMPT_LIMIT 5'h10
`define MIN_PAYLOAD 16'h002E
`define HEADER_BYTES 11'h00E
`define LEN_HI_IDX 11'h00C
`define LEN_LO_IDX 11'h00D
`endif

// ==== src/host_mac_tx_rx_control.sv ====
// host mac control register with receive stripping, transmit backoff, deferral check and enables
`timescale 1ns/1ns
// Notes on behaviour
// - strip pad when length below 46
// - strip check sequence along with pad
// - long frames pass unchanged with check sequence
// - stripping off passes every frame whole
// - backoff random r below two to K
// - shift register bits give backoff count
// - one slot equals 512 bit times
// - abort after deferring over 24288 bits
// - defer counted only while carrier blocks
// - deferral timer restarts after each backoff
// - check off means no deferral aborts
// - transmit only while transmit enable set; a send or backoff under way runs on after it clears
// - receive only while receive enable set; enable is sampled at the first byte, so an admitted frame completes
module host_mac_tx_rx_control
  import host_mac_pkg::*;
#(
  parameter int          CLK_MHZ   = 125,      // core clock rate
  parameter int          BIT_MHZ   = 100,      // link bit rate
  parameter logic [15:0] LFSR_SEED = 16'hACE1  // backoff start value
) (
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic [11:0]  paddr,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire byte_stream_s rx_in,
  output byte_stream_s      rx_out,
  input  wire logic         tx_frame_pending,
  input  wire logic         carrier_sense,
  input  wire logic         tx_collision,
  input  wire logic         tx_frame_done,
  output logic              tx_active,
  output logic              tx_attempt,
  output logic              tx_abort_deferral,
  output logic              tx_abort_retries,
  output logic              tx_complete
);
  `include "host_mac_regs.svh"

  // ****************************************
  // control and status registers
  // ****************************************
  logic [31:0] ctrl_q;    // control word
  logic [31:0] prdata_q;  // read data captured at setup
  tx_state_e   state_q;   // transmit sequencer
  logic [4:0]  retry_q;   // collisions on current frame
  logic        last_def_q;  // last frame dropped for deferral
  logic        last_ret_q;  // last frame dropped for retries

  wire logic       pad_strip_enable      = ctrl_q[`PAD_STRIP_BIT];
  wire logic [1:0] backoff_limit_select  = ctrl_q[`BACKOFF_SEL_MSB:`BACKOFF_SEL_LSB];
  wire logic       deferral_check_enable = ctrl_q[`DEFER_CHK_BIT];
  wire logic       transmit_enable       = ctrl_q[`TX_EN_BIT];
  wire logic       receive_enable        = ctrl_q[`RX_EN_BIT];

  // bus decode
  wire logic ctrl_hit   = (paddr == `CTRL_ADDR);
  wire logic status_hit = (paddr == `STATUS_ADDR);
  wire logic mapped     = ctrl_hit || status_hit;
  wire logic setup      = psel && !penable;
  wire logic access     = psel && penable;
  wire logic ctrl_wr    = access && pwrite && ctrl_hit;
  // byte lanes limited to writable bits
  wire logic [31:0] lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire logic [31:0] wmask     = lane_mask & `CTRL_WMASK;
  wire logic [31:0] ctrl_d    = (ctrl_q & ~wmask) | (pwdata & wmask);
  // status word shows sequencer state
  wire logic [31:0] status_word = {19'h00000, retry_q, 2'h0, last_ret_q, last_def_q,
                                   state_q};
  wire logic [31:0] read_word = ctrl_hit ? (ctrl_q & `CTRL_WMASK) :
                                status_hit ? status_word : 32'h00000000;

  // zero wait slave, error on unmapped access
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = prdata_q;

  // control register write
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl_q <= `CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= ctrl_d;
    end
  end

  // read data captured in setup, stable through access
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prdata_q <= 32'h00000000;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h00000000 : read_word;
    end
  end

  // ****************************************
  // receive gating at frame boundaries
  // ****************************************
  logic in_frame_q;  // middle of a received frame
  logic accept_q;    // current frame admitted
  // decide admission on the first byte only, so no frame is cut
  wire logic admit = in_frame_q ? accept_q : receive_enable;
  byte_stream_s rx_gated;  // stream after enable gating
  assign rx_gated = '{valid: rx_in.valid && admit, last: rx_in.last, data: rx_in.data};

  // track frame boundary and admission
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      in_frame_q <= 1'b0;
      accept_q   <= 1'b0;
    end else if (rx_in.valid) begin
      in_frame_q <= !rx_in.last;
      accept_q   <= admit;
    end
  end

  // pad and check sequence stripping
  rx_pad_strip u_strip (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .strip_en (pad_strip_enable),
    .in_byte  (rx_gated),
    .out_byte (rx_out)
  );

  // ****************************************
  // bit time enable from the core clock
  // ****************************************
  logic [7:0] acc_q;  // fractional bit phase
  wire logic [8:0] acc_sum = {1'b0, acc_q} + 9'(BIT_MHZ);
  wire logic       bit_tick = (acc_sum >= 9'(CLK_MHZ));  // one bit time elapsed
  wire logic [7:0] acc_d = bit_tick ? 8'(acc_sum - 9'(CLK_MHZ)) : acc_sum[7:0];

  // phase accumulator
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      acc_q <= 8'h00;
    end else begin
      acc_q <= acc_d;
    end
  end

  // ****************************************
  // backoff draw
  // ****************************************
  logic [15:0] lfsr_q;  // random source

  backoff_lfsr #(
    .SEED (LFSR_SEED)
  ) u_lfsr (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .state_q  (lfsr_q)
  );

  // mask of K low bits, K the least of retries, 10 and the limit cap
  function automatic logic [9:0] backoff_mask(input logic [4:0] n, input logic [1:0] sel);
    logic [3:0] cap;
    logic [3:0] k;
    case (sel)
      2'h0:    cap = 4'hA;  // full ten bit range
      2'h1:    cap = 4'h8;
      2'h2:    cap = 4'h4;
      default: cap = 4'h1;
    endcase
    k = (n > {1'b0, cap}) ? cap : n[3:0];
    backoff_mask = 10'((11'h001 << k) - 11'h001);
  endfunction : backoff_mask

  // ****************************************
  // transmit sequencer
  // ****************************************
  tx_state_e   state_d;
  logic [15:0] defer_q;   // deferral in bit times
  logic [15:0] defer_d;
  logic [4:0]  retry_d;
  logic [9:0]  slots_q;   // slots still to wait
  logic [9:0]  slots_d;
  logic [8:0]  sbit_q;    // bit inside the current slot
  logic [8:0]  sbit_d;
  logic        attempt_d;
  logic        abort_def_d;
  logic        abort_ret_d;
  logic        complete_d;

  wire logic defer_over = deferral_check_enable && (defer_q > `DEFER_LIMIT_BITS);
  wire logic [4:0] retry_inc = retry_q + 5'h01;
  wire logic [9:0] draw = lfsr_q[9:0] & backoff_mask(retry_inc, backoff_limit_select);

  // next state and counters
  always_comb begin
    state_d     = state_q;
    defer_d     = defer_q;
    retry_d     = retry_q;
    slots_d     = slots_q;
    sbit_d      = sbit_q;
    attempt_d   = 1'b0;
    abort_def_d = 1'b0;
    abort_ret_d = 1'b0;
    complete_d  = 1'b0;
    case (state_q)
      TX_IDLE: begin
        // a new frame starts only when enabled
        if (transmit_enable && tx_frame_pending) begin
          state_d = TX_DEFER;
          defer_d = 16'h0000;
          retry_d = 5'h00;
        end
      end
      TX_DEFER: begin
        if (!transmit_enable) begin
          state_d = TX_IDLE;
        end else if (carrier_sense) begin
          if (defer_over) begin
            state_d     = TX_IDLE;
            abort_def_d = 1'b1;
          end else if (bit_tick && defer_q != 16'hFFFF) begin
            defer_d = defer_q + 16'h0001;
          end
        end else begin
          state_d   = TX_SEND;
          attempt_d = 1'b1;
        end
      end
      TX_SEND: begin
        if (tx_collision) begin
          retry_d = retry_inc;
          if (retry_inc == `ATTEMPT_LIMIT) begin
            state_d     = TX_IDLE;
            abort_ret_d = 1'b1;
          end else begin
            state_d = TX_BACKOFF;
            slots_d = draw;
            sbit_d  = 9'h000;
          end
        end else if (tx_frame_done) begin
          state_d    = TX_IDLE;
          complete_d = 1'b1;
        end
      end
      TX_BACKOFF: begin
        if (slots_q == 10'h000) begin
          state_d = TX_DEFER;
          defer_d = 16'h0000;
        end else if (bit_tick) begin
          if (sbit_q == `SLOT_LAST_BIT) begin
            sbit_d  = 9'h000;
            slots_d = slots_q - 10'h001;
          end else begin
            sbit_d = sbit_q + 9'h001;
          end
        end
      end
      default: begin
        state_d = TX_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= TX_IDLE;
      defer_q <= 16'h0000;
      retry_q <= 5'h00;
      slots_q <= 10'h000;
      sbit_q  <= 9'h000;
    end else begin
      state_q <= state_d;
      defer_q <= defer_d;
      retry_q <= retry_d;
      slots_q <= slots_d;
      sbit_q  <= sbit_d;
    end
  end

  // event pulses and last outcome flags
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tx_attempt        <= 1'b0;
      tx_abort_deferral <= 1'b0;
      tx_abort_retries  <= 1'b0;
      tx_complete       <= 1'b0;
      last_def_q        <= 1'b0;
      last_ret_q        <= 1'b0;
    end else begin
      tx_attempt        <= attempt_d;
      tx_abort_deferral <= abort_def_d;
      tx_abort_retries  <= abort_ret_d;
      tx_complete       <= complete_d;
      if (abort_def_d || abort_ret_d || complete_d) begin
        last_def_q <= abort_def_d;
        last_ret_q <= abort_ret_d;
      end
    end
  end

  assign tx_active = (state_q == TX_SEND);

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_tx_disabled_hold: assert property (state_q == TX_IDLE && !transmit_enable
    |=> state_q == TX_IDLE)
    else $error("transmit started while disabled");
  a_defer_abort_now: assert property (state_q == TX_DEFER && transmit_enable && carrier_sense
    && deferral_check_enable && defer_q > `DEFER_LIMIT_BITS |=> tx_abort_deferral && state_q == TX_IDLE)
    else $error("excess deferral not aborted");
  a_no_abort_unchecked: assert property (tx_abort_deferral |-> $past(deferral_check_enable)
    && $past(defer_q) > `DEFER_LIMIT_BITS)
    else $error("deferral abort without check");
  a_defer_needs_carrier: assert property (defer_q > $past(defer_q) |-> $past(carrier_sense)
    && $past(state_q) == TX_DEFER)
    else $error("deferral counted without carrier");
  a_defer_fresh_start: assert property (state_q == TX_BACKOFF ##1 state_q == TX_DEFER
    |-> defer_q == 16'h0000)
    else $error("deferral time carried over");
  a_backoff_range: assert property (state_q == TX_BACKOFF
    |-> slots_q <= backoff_mask(retry_q, backoff_limit_select))
    else $error("backoff count out of range");
  a_slot_length: assert property (state_q == TX_BACKOFF && slots_q < $past(slots_q)
    |-> $past(sbit_q) == `SLOT_LAST_BIT && $past(bit_tick))
    else $error("slot ended early");
  a_rx_disabled_drop: assert property (rx_in.valid && !in_frame_q && !receive_enable
    |-> !rx_gated.valid ##1 !rx_out.valid)
    else $error("frame accepted while receiver off");

  c_defer_abort: cover property (tx_abort_deferral);
  c_backoff_wait: cover property (state_q == TX_BACKOFF && slots_q > 10'h002);
  c_frame_done: cover property (tx_attempt ##[1:50] tx_complete);
endmodule : host_mac_tx_rx_control

// ==== src/rx_pad_strip.sv ====
// removes pad and check sequence from short received frames
`timescale 1ns/1ns
module rx_pad_strip
  import host_mac_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         reset_n,
  input  wire logic         strip_en,
  input  wire byte_stream_s in_byte,
  output byte_stream_s      out_byte
);
  `include "host_mac_regs.svh"
  logic [10:0] idx_q;     // byte position inside the frame
  logic [7:0]  len_hi_q;  // upper length byte
  logic [15:0] len_q;     // full length field
  // length seen at the low length byte itself
  wire logic [15:0] len_now = (idx_q == `LEN_LO_IDX) ? {len_hi_q, in_byte.data} : len_q;
  wire logic        short_frame = (idx_q >= `LEN_LO_IDX) && (len_now < `MIN_PAYLOAD);
  wire logic [10:0] last_keep = `LEN_LO_IDX + len_now[10:0];  // last payload byte
  wire logic        stripping = strip_en && short_frame;
  // drop pad and check sequence past the payload
  wire logic keep = !stripping || (idx_q <= last_keep);
  wire logic cut_last = stripping && (idx_q == last_keep);
  // ****************************************
  // frame position and length capture
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      idx_q    <= 11'h000;
      len_hi_q <= 8'h00;
      len_q    <= 16'hFFFF;
    end else if (in_byte.valid) begin
      idx_q <= in_byte.last ? 11'h000 : idx_q + 11'h001;
      if (idx_q == `LEN_HI_IDX) len_hi_q <= in_byte.data;
      if (idx_q == `LEN_LO_IDX) len_q <= len_now;
      if (in_byte.last) len_q <= 16'hFFFF;
    end
  end
  // registered output stage
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      out_byte <= '0;
    end else begin
      out_byte.valid <= in_byte.valid && keep;
      out_byte.last  <= in_byte.last || cut_last;
      out_byte.data  <= in_byte.data;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_pass_when_off: assert property (in_byte.valid && !strip_en |=> out_byte.valid)
    else $error("byte lost while stripping disabled");
  a_long_kept: assert property (in_byte.valid && idx_q > `LEN_LO_IDX && len_q >= `MIN_PAYLOAD
    |=> out_byte.valid && out_byte.data == $past(in_byte.data))
    else $error("byte of long frame not passed");
  a_pad_dropped: assert property (in_byte.valid && strip_en && short_frame
    && idx_q > last_keep |=> !out_byte.valid)
    else $error("pad or check byte passed");
  c_short_cut: cover property (in_byte.valid && cut_last);
endmodule : rx_pad_strip
